// ### src/pmc_pkg.sv
// Package for the port-merge configuration block: constants and carrier structs
package pmc_pkg;

  localparam int NUM_PORTS      = 7;
  localparam int LANES_PER_PORT = 4;
  localparam int MERGED_LANES   = 8;
  localparam int UPSTREAM_PORT  = 0;
  localparam int MERGE_EVEN     = 0;
  localparam int MERGE_ODD      = 1;

  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X8 = 6'h08;

  localparam logic       MERGE_RST  = 1'h0;
  localparam logic [2:0] STATE_BITS = 3'h0;

  // Configuration request from the upstream side
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] dev;
  } pmc_cfg_req_s;

  // Completion status of a configuration request
  typedef struct packed {
    logic       valid;
    logic       unsupported;
    logic [2:0] dev;
  } pmc_cfg_cpl_s;

  // Sideband outputs of one downstream port
  typedef struct packed {
    logic hp_power_en;
    logic hp_attn_led;
    logic link_up;
    logic port_reset_n;
  } pmc_port_out_s;

  // Sideband inputs of one downstream port
  typedef struct packed {
    logic hp_present;
    logic hp_attn_button;
    logic link_active;
  } pmc_port_in_s;

  typedef enum logic [1:0] {
    PMC_IN_RESET = 2'b00,
    PMC_SAMPLE   = 2'b01,
    PMC_RUN      = 2'b10
  } pmc_state_e;

  function automatic logic pmc_port1_off(input logic merged);
    return merged;
  endfunction

endpackage

// ### src/pmc_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pmc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en) begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end

  assign dout = s2_q;
endmodule

// ### src/pmc_top.sv
// Port-merge configuration: strap capture, lane steering, port 1 gating, config decode
//
// Contract
// - Each unmerged port carries four serial lanes.
// - Port 0 is always upstream; ports 1 to 6 always downstream.
// - Even port and next odd port may merge as x8 under the even number.
// - Merge setting is fixed only in fundamental reset, never during operation.
// - Asserted merge strap combines x4 ports 0 and 1 into one x8 port.
// - When merged, port 1, its bridge and all its resources are disabled.
// - When merged, every port 1 output stays negated.
// - When merged, every port 1 input is ignored.
// - When merged, config accesses to port 1 device end as unsupported request.
// - When merged, port 1 lanes serve as port 0 lanes 4 to 7.
// - When merged, maximum link width field resets to x8.
// - Board holds strap during reset; device samples it at reset release only.
`timescale 1ns/10ps
module pmc_top
  import pmc_pkg::*;
(
  input  wire logic                                   clk_sys,
  input  wire logic                                   rst_n,
  input  wire logic                                   clk_en,
  input  wire logic                                   fundamental_reset_n,
  input  wire logic                                   merge_pair_strap,
  input  wire logic [LANES_PER_PORT-1:0]              p0_lane_rx,
  input  wire logic [LANES_PER_PORT-1:0]              p1_lane_rx,
  input  wire logic [LANES_PER_PORT-1:0]              p0_lane_tx_core,
  input  wire logic [LANES_PER_PORT-1:0]              p0_lane_tx_hi_core,
  input  wire logic [LANES_PER_PORT-1:0]              p1_lane_tx_core,
  input  wire pmc_port_out_s                          p1_out_core,
  input  wire pmc_port_in_s                           p1_in_pin,
  input  wire pmc_cfg_req_s                           cfg_req,
  output logic [MERGED_LANES-1:0]                     p0_lane_rx_core,
  output logic [LANES_PER_PORT-1:0]                   p1_lane_rx_core,
  output logic [LANES_PER_PORT-1:0]                   p0_lane_tx,
  output logic [LANES_PER_PORT-1:0]                   p1_lane_tx,
  output pmc_port_out_s                               p1_out_pin,
  output pmc_port_in_s                                p1_in_core,
  output pmc_cfg_cpl_s                                cfg_cpl,
  output logic                                        merged,
  output logic                                        p1_enable,
  output logic [5:0]                                  max_link_width_field,
  output logic [2:0]                                  upstream_port_num,
  output logic                                        cfg_ready
);

  // Pin inputs pass two flops before use
  logic       perst_s;
  logic       strap_s;
  pmc_port_in_s p1_in_s;

  pmc_sync2 #(.W(2)) u_sync_sys (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .din     ({fundamental_reset_n, merge_pair_strap}),
    .dout    ({perst_s, strap_s})
  );

  pmc_sync2 #(.W($bits(pmc_port_in_s))) u_sync_p1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .din     (p1_in_pin),
    .dout    (p1_in_s)
  );

  // Link width reported for a merge setting
  function automatic logic [5:0] width_for(input logic mrg);
    logic [5:0] w;
    w = WIDTH_X4;
    if (mrg) begin
      w = WIDTH_X8;
    end
    return w;
  endfunction

  // Strap capture state machine
  pmc_state_e state_q;
  pmc_state_e state_d;
  logic       merge_q;
  logic       merge_d;
  logic [5:0] width_q;
  logic [5:0] width_d;

  always_comb begin
    state_d = state_q;
    merge_d = merge_q;
    width_d = width_q;
    case (state_q)
      PMC_IN_RESET: begin
        if (perst_s) begin
          state_d = PMC_SAMPLE;
        end
      end
      PMC_SAMPLE: begin
        merge_d = strap_s;
        width_d = width_for(strap_s);
        state_d = PMC_RUN;
      end
      PMC_RUN: begin
        if (!perst_s) begin
          state_d = PMC_IN_RESET;
        end
      end
      default: begin
        state_d = PMC_IN_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= PMC_IN_RESET;
      merge_q <= MERGE_RST;
      width_q <= WIDTH_X4;
    end else if (clk_en) begin
      state_q <= state_d;
      merge_q <= merge_d;
      width_q <= width_d;
    end
  end

  assign merged               = merge_q;
  assign p1_enable            = !pmc_port1_off(merge_q);
  assign max_link_width_field = width_q;
  assign upstream_port_num    = 3'(UPSTREAM_PORT);

  // Receive lane steering
  always_comb begin
    p0_lane_rx_core = {4'h0, p0_lane_rx};
    p1_lane_rx_core = p1_lane_rx;
    if (merge_q) begin
      p0_lane_rx_core = {p1_lane_rx, p0_lane_rx};
      p1_lane_rx_core = 4'h0;
    end
  end

  // Transmit lane steering
  always_comb begin
    p0_lane_tx = p0_lane_tx_core;
    p1_lane_tx = p1_lane_tx_core;
    if (merge_q) begin
      p1_lane_tx = p0_lane_tx_hi_core;
    end
  end

  // Port 1 sideband gating, registered
  pmc_port_out_s p1_out_q;
  pmc_port_out_s p1_out_d;
  pmc_port_in_s  p1_in_q;
  pmc_port_in_s  p1_in_d;
  localparam pmc_port_out_s OUT_NEG = '{hp_power_en: 1'b0, hp_attn_led: 1'b0,
                                        link_up: 1'b0, port_reset_n: 1'b1};

  // Port 1 sideband stays quiet while merged or outside normal operation
  logic          p1_quiet;
  assign p1_quiet = merge_q || (state_q != PMC_RUN);

  always_comb begin
    p1_out_d = p1_out_core;
    p1_in_d  = p1_in_s;
    if (p1_quiet) begin
      p1_out_d = OUT_NEG;
      p1_in_d  = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      p1_out_q <= OUT_NEG;
      p1_in_q  <= '0;
    end else if (clk_en) begin
      p1_out_q <= p1_out_d;
      p1_in_q  <= p1_in_d;
    end
  end

  assign p1_out_pin = p1_out_q;
  assign p1_in_core = p1_in_q;

  // Configuration decode on the virtual bus
  // Virtual-bus device of port 1, and the last device present
  localparam logic [2:0] DEV_PORT1 = 3'(MERGE_ODD - 1);
  localparam logic [2:0] DEV_LAST  = 3'(NUM_PORTS - 2);

  // Absent devices, and port 1 while merged, answer as unsupported
  function automatic logic dev_unsupported(
    input logic [2:0] dev,
    input logic       mrg
  );
    logic absent;
    logic hidden;
    absent = (dev > DEV_LAST);
    hidden = mrg && (dev == DEV_PORT1);
    return absent || hidden;
  endfunction

  pmc_cfg_cpl_s cpl_q;
  pmc_cfg_cpl_s cpl_d;

  assign cfg_ready = (state_q == PMC_RUN);

  always_comb begin
    cpl_d = '0;
    if (cfg_req.valid && cfg_ready) begin
      cpl_d.valid       = 1'b1;
      cpl_d.dev         = cfg_req.dev;
      cpl_d.unsupported = dev_unsupported(cfg_req.dev, merge_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cpl_q <= '0;
    end else if (clk_en) begin
      cpl_q <= cpl_d;
    end
  end

  assign cfg_cpl = cpl_q;

endmodule

// ### verif/pmc_top_sva.sv
// Port-merge checker bound to the top module
`timescale 1ns/10ps
module pmc_top_sva
  import pmc_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          rst_n,
  input wire logic          clk_en,
  input wire logic [3:0]    p0_lane_rx,
  input wire logic [3:0]    p1_lane_rx,
  input wire logic [3:0]    p0_lane_tx_hi_core,
  input wire pmc_cfg_req_s  cfg_req,
  input wire logic [7:0]    p0_lane_rx_core,
  input wire logic [3:0]    p1_lane_tx,
  input wire pmc_port_out_s p1_out_pin,
  input wire pmc_port_in_s  p1_in_core,
  input wire pmc_cfg_cpl_s  cfg_cpl,
  input wire logic          merged,
  input wire logic          p1_enable,
  input wire logic [5:0]    max_link_width_field,
  input wire logic          cfg_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_cfg_answer: assert property (cfg_req.valid && cfg_ready && clk_en |=> cfg_cpl.valid
    && cfg_cpl.dev == $past(cfg_req.dev)) else $error("No completion");
  a_p1_unsup: assert property (cfg_req.valid && cfg_ready && clk_en && cfg_req.dev == 3'h0
    |=> cfg_cpl.unsupported == merged) else $error("Port 1 status wrong");
  a_dev_absent: assert property (cfg_req.valid && cfg_ready && clk_en && cfg_req.dev >= 3'h6
    |=> cfg_cpl.unsupported) else $error("Absent device answered");
  a_width_value: assert property (max_link_width_field == (merged ? WIDTH_X8 : WIDTH_X4))
    else $error("Width wrong");
  a_out_negated: assert property (merged |-> p1_out_pin == 4'h1)
    else $error("Port 1 output active");
  a_in_ignored: assert property (merged |-> p1_in_core == 3'h0)
    else $error("Port 1 input passed");
  a_rx_steer: assert property (merged |-> p0_lane_rx_core == {p1_lane_rx, p0_lane_rx})
    else $error("Rx steering wrong");
  a_tx_steer: assert property (merged |-> p1_lane_tx == p0_lane_tx_hi_core)
    else $error("Tx steering wrong");
  a_p1_off: assert property (merged |-> !p1_enable)
    else $error("Port 1 enabled");
  a_merge_hold: assert property (cfg_ready && $past(cfg_ready) |-> $stable(merged))
    else $error("Merge changed in run");
endmodule
bind pmc_top pmc_top_sva u_sva (.clk_sys, .rst_n, .clk_en, .p0_lane_rx, .p1_lane_rx,
  .p0_lane_tx_hi_core, .cfg_req, .p0_lane_rx_core, .p1_lane_tx, .p1_out_pin,
  .p1_in_core, .cfg_cpl, .merged, .p1_enable, .max_link_width_field, .cfg_ready);

// ### verif/pmc_root_model.sv
// Upstream root model issuing configuration requests
`timescale 1ns/10ps
module pmc_root_model
  import pmc_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire pmc_cfg_cpl_s cfg_cpl,
  output pmc_cfg_req_s      cfg_req
);
  initial cfg_req = '0;
  task automatic send(input logic [2:0] d, input logic w, output logic u, output logic ok);
    @(posedge clk_sys);
    cfg_req <= '{1'b1, w, d};
    @(posedge clk_sys);
    cfg_req <= '{1'b0, ~w, ~d};
    #1;
    ok = cfg_cpl.valid === 1'b1 && cfg_cpl.dev === d;
    u = cfg_cpl.unsupported;
  endtask
endmodule

// ### verif/pmc_top_bench.sv
// Testbench for port-merge configuration
`timescale 1ns/10ps
module pmc_top_bench import pmc_pkg::*;;
  logic          clk_sys, rst_n, clk_en, fundamental_reset_n, merge_pair_strap, u, ok;
  logic          merged, p1_enable, cfg_ready;
  logic [3:0]    p0_lane_rx, p1_lane_rx, p0_lane_tx_core, p0_lane_tx_hi_core, p1_lane_tx_core;
  logic [3:0]    p1_lane_rx_core, p0_lane_tx, p1_lane_tx;
  logic [7:0]    p0_lane_rx_core;
  logic [5:0]    max_link_width_field;
  logic [2:0]    upstream_port_num;
  pmc_port_out_s p1_out_core, p1_out_pin;
  pmc_port_in_s  p1_in_pin, p1_in_core;
  pmc_cfg_req_s  cfg_req;
  pmc_cfg_cpl_s  cfg_cpl;
  int            n_fail = 0;
  int            check_count = 0;
  pmc_top DUT (.clk_sys, .rst_n, .clk_en, .fundamental_reset_n, .merge_pair_strap,
    .p0_lane_rx, .p1_lane_rx, .p0_lane_tx_core, .p0_lane_tx_hi_core, .p1_lane_tx_core,
    .p1_out_core, .p1_in_pin, .cfg_req, .p0_lane_rx_core, .p1_lane_rx_core, .p0_lane_tx,
    .p1_lane_tx, .p1_out_pin, .p1_in_core, .cfg_cpl, .merged, .p1_enable,
    .max_link_width_field, .upstream_port_num, .cfg_ready);
  pmc_root_model root (.clk_sys, .cfg_cpl, .cfg_req);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic boot(input logic s);
    @(posedge clk_sys);
    fundamental_reset_n <= 1'b0;
    merge_pair_strap <= s;
    repeat (4) @(posedge clk_sys);
    fundamental_reset_n <= 1'b1;
    for (int n = 0; n < 20 && cfg_ready !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    merge_pair_strap <= ~s;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_merged();
    boot(1'b1);
    chk({7'h0, merged}, 8'h1);
    chk({2'h0, max_link_width_field}, 8'h8);
    chk(p0_lane_rx_core, 8'ha5);
    chk({p1_lane_tx, p0_lane_tx}, 8'hc3);
    chk({1'b0, p1_in_core, p1_lane_rx_core}, 8'h00);
    chk({3'h0, p1_out_pin, p1_enable}, 8'h02);
    root.send(3'h0, 1'b1, u, ok);
    chk({6'h0, ok, u}, 8'h3);
    root.send(3'h1, 1'b0, u, ok);
    chk({6'h0, ok, u}, 8'h2);
  endtask
  task automatic t_unmerged();
    boot(1'b0);
    chk({7'h0, merged}, 8'h0);
    chk({2'h0, max_link_width_field}, 8'h4);
    chk(p0_lane_rx_core, 8'h05);
    chk({p1_lane_tx, p0_lane_tx}, 8'h63);
    chk({1'b0, p1_in_core, p1_lane_rx_core}, 8'h7a);
    chk({1'b0, upstream_port_num, p1_out_pin}, 8'h0a);
    root.send(3'h0, 1'b0, u, ok);
    chk({6'h0, ok, u}, 8'h2);
    root.send(3'h6, 1'b1, u, ok);
    chk({6'h0, ok, u}, 8'h3);
  endtask
  task automatic t_freeze();
    @(posedge clk_sys);
    clk_en <= 1'b0;
    root.send(3'h6, 1'b0, u, ok);
    chk({6'h0, ok, u}, 8'h0);
    chk({7'h0, merged}, 8'h0);
    @(posedge clk_sys);
    clk_en <= 1'b1;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (600) @(posedge clk_sys);
    n_fail++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    fundamental_reset_n = 1'b0;
    merge_pair_strap = 1'b0;
    {p0_lane_rx, p1_lane_rx, p0_lane_tx_core, p0_lane_tx_hi_core} = 16'h5a3c;
    p1_lane_tx_core = 4'h6;
    p1_out_core = 4'ha;
    p1_in_pin = 3'h7;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_merged();
    t_unmerged();
    t_freeze();
    end_of_test();
  end
endmodule
